//--- hw/sysbus_pkg.sv
/*
  Constants and types shared by the system bus master.
  Assumes a big-endian 32-bit data bus whose lane D[0:7] maps onto bits 31:24.
*/
package sysbus_pkg;

  // Bus and buffer widths.
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned BUF_W       = 128;
  localparam int unsigned BLOCK_BYTES = 16;

  // Transfer size codes driven with the address.
  localparam logic [1:0] TSIZ_WORD = 2'h0;
  localparam logic [1:0] TSIZ_BYTE = 2'h1;
  localparam logic [1:0] TSIZ_HALF = 2'h2;

  // Port size codes reported by a slave behind the memory controller.
  localparam logic [1:0] PORT_32 = 2'h0;
  localparam logic [1:0] PORT_8  = 2'h1;
  localparam logic [1:0] PORT_16 = 2'h2;

  // Beat counts and bytes per beat.
  localparam logic [4:0] BEATS_SINGLE = 5'h01;
  localparam logic [4:0] BEATS_BURST  = 5'h04;
  localparam logic [4:0] BEATS_HALF   = 5'h08;
  localparam logic [4:0] BEATS_BYTE   = 5'h10;
  localparam logic [3:0] STEP_WORD    = 4'h4;
  localparam logic [3:0] STEP_HALF    = 4'h2;
  localparam logic [3:0] STEP_BYTE    = 4'h1;

  // Reset values.
  localparam logic [3:0]        OFF_RESET  = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [BUF_W-1:0]  BUF_RESET  = 128'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARB  = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_TURN = 3'b100,
    ST_REL  = 3'b101
  } bus_state_t;

endpackage

//--- hw/sysbus_master.sv
/*
  External system bus master: arbitration, address, data and termination
  phases, single beats, 4-beat bursts, narrow 8/16-beat bursts and the
  burst-inhibit fallback into single transfers.
  Assumes the bus logic runs on the bus clock input and the user side on
  clk_in; the user holds no signal after the accepting handshake.
*/
`timescale 1ns/100ps

// Contract
// - Bus signals change and sample on bus clock.
// - Arbitration, address, data, termination in order.
// - One beat, or 4x4, 8x2, 16x1 bursts.
// - Write data driven from cycle after address.
// - One dead cycle between data bus drivers.
// - Write data released once acknowledge sampled.
// - Read data captured on acknowledge edge.
// - 32-bit default; narrow only via memory controller.
// - Burst covers aligned 16-byte block, any start.
// - Attributes stable; slave acknowledges each beat.
// - Burst inhibit: end, then 3/7/15 singles.
// - Narrow port indicated early gives 8/16 beats.
// - Narrow burst atomic, no arbitration between.
// - Burst starts with address, attributes, start.
// - Burst write: continue flag until last beat.
// - Write acknowledge, then next beat and flag.
// - Burst read: negate continue before last beat.
// - Natural alignment for half, word and burst.
module sysbus_master (
  // User clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         resetn_in,
  // User request
  input  wire logic                         req_valid_in,
  output logic                              req_ready_out,
  input  wire logic                         req_write_in,
  input  wire logic                         req_burst_in,
  input  wire logic                         req_mc_in,
  input  wire logic [1:0]                   req_size_in,
  input  wire logic [sysbus_pkg::ADDR_W-1:0] req_addr_in,
  input  wire logic [sysbus_pkg::BUF_W-1:0]  req_wdata_in,
  // User answer
  output logic                              done_out,
  output logic [sysbus_pkg::BUF_W-1:0]      rdata_out,
  // Bus clock
  input  wire logic                         bus_clock_output_in,
  // Arbitration
  output logic                              bus_req_n_out,
  input  wire logic                         bus_grant_n_in,
  input  wire logic                         bus_busy_n_in,
  output logic                              bus_busy_n_out,
  output logic                              bus_busy_oe_out,
  // Address phase
  output logic [sysbus_pkg::ADDR_W-1:0]     addr_out,
  output logic [1:0]                        tsiz_out,
  output logic                              write_out,
  output logic                              burst_out,
  output logic                              xfer_start_n_out,
  // Data phase
  input  wire logic [sysbus_pkg::DATA_W-1:0] data_in,
  output logic [sysbus_pkg::DATA_W-1:0]     data_out,
  output logic                              data_oe_out,
  input  wire logic                         beat_ack_n_in,
  input  wire logic                         no_burst_flag_n_in,
  output logic                              burst_continues_n_out,
  input  wire logic [1:0]                   port_size_in
);
  import sysbus_pkg::*;

  // User domain state.
  logic              busy_ff;
  logic              req_tgl_ff;
  logic              done_s1_ff;
  logic              done_s2_ff;
  logic              done_seen_ff;
  logic              done_pulse_ff;
  logic              u_write_ff;
  logic              u_burst_ff;
  logic              u_mc_ff;
  logic [1:0]        u_size_ff;
  logic [ADDR_W-1:0] u_addr_ff;
  logic [BUF_W-1:0]  u_wdata_ff;
  logic [BUF_W-1:0]  rdata_ff;

  // Bus domain state.
  logic              brst_s1_ff;
  logic              brst_s2_ff;
  logic              req_s1_ff;
  logic              req_s2_ff;
  logic              req_seen_ff;
  logic              done_tgl_ff;
  bus_state_t        state_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [3:0]        off_ff;
  logic              write_ff;
  logic              burst_mode_ff;
  logic              mc_ff;
  logic              first_ff;
  logic              own_ff;
  logic [1:0]        usize_ff;
  logic [1:0]        psz_ff;
  logic [1:0]        psz_prev_ff;
  logic [4:0]        beats_left_ff;
  logic [BUF_W-1:0]  buf_ff;

  logic              brst_n;
  logic [1:0]        eff_psz;
  logic [3:0]        step;
  logic [4:0]        blk_beats;
  logic              ack;
  logic [BUF_W-1:0]  nxt_buf;

  // User side: accept a request, hand it over by toggle, collect the answer.
  assign req_ready_out = ~busy_ff;
  assign done_out      = done_pulse_ff;
  assign rdata_out     = rdata_ff;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      busy_ff    <= 1'b0;
      req_tgl_ff <= 1'b0;
      u_write_ff <= 1'b0;
      u_burst_ff <= 1'b0;
      u_mc_ff    <= 1'b0;
      u_size_ff  <= TSIZ_WORD;
      u_addr_ff  <= ADDR_RESET;
      u_wdata_ff <= BUF_RESET;
    end else if (req_valid_in && !busy_ff) begin
      busy_ff    <= 1'b1;
      req_tgl_ff <= ~req_tgl_ff;
      u_write_ff <= req_write_in;
      u_burst_ff <= req_burst_in;
      u_mc_ff    <= req_mc_in;
      u_size_ff  <= req_burst_in ? TSIZ_WORD : req_size_in;
      u_addr_ff  <= req_addr_in;
      u_wdata_ff <= req_burst_in ? req_wdata_in : {4{req_wdata_in[DATA_W-1:0]}};
    end else if (done_s2_ff != done_seen_ff) begin
      busy_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_s1_ff    <= 1'b0;
      done_s2_ff    <= 1'b0;
      done_seen_ff  <= 1'b0;
      done_pulse_ff <= 1'b0;
      rdata_ff      <= BUF_RESET;
    end else begin
      done_s1_ff    <= done_tgl_ff;
      done_s2_ff    <= done_s1_ff;
      done_seen_ff  <= done_s2_ff;
      done_pulse_ff <= done_s2_ff != done_seen_ff;
      // The bus buffer stays still until the next request, so it is safe here.
      if (done_s2_ff != done_seen_ff) begin
        rdata_ff <= buf_ff;
      end
    end
  end

  // Reset release is synchronised onto the bus clock.
  always_ff @(posedge bus_clock_output_in or negedge resetn_in) begin
    if (!resetn_in) begin
      brst_s1_ff <= 1'b0;
      brst_s2_ff <= 1'b0;
    end else begin
      brst_s1_ff <= 1'b1;
      brst_s2_ff <= brst_s1_ff;
    end
  end
  assign brst_n = brst_s2_ff;

  always_ff @(posedge bus_clock_output_in or negedge brst_n) begin
    if (!brst_n) begin
      req_s1_ff   <= 1'b0;
      req_s2_ff   <= 1'b0;
      psz_prev_ff <= PORT_32;
    end else begin
      req_s1_ff   <= req_tgl_ff;
      req_s2_ff   <= req_s1_ff;
      psz_prev_ff <= port_size_in;
    end
  end

  // Port size in force for this beat; a narrow size counts only when it was
  // shown the cycle before the first acknowledge on a controller slave.
  assign eff_psz = (first_ff && mc_ff) ? psz_prev_ff : psz_ff;
  assign ack     = (state_ff == ST_DATA) && !beat_ack_n_in;

  always_comb begin
    case (eff_psz)
      PORT_16: begin
        step      = STEP_HALF;
        blk_beats = BEATS_HALF;
      end
      PORT_8: begin
        step      = STEP_BYTE;
        blk_beats = BEATS_BYTE;
      end
      default: begin
        step      = STEP_WORD;
        blk_beats = BEATS_BURST;
      end
    endcase
  end

  // Transaction sequencer.
  always_ff @(posedge bus_clock_output_in or negedge brst_n) begin
    if (!brst_n) begin
      state_ff      <= ST_IDLE;
      req_seen_ff   <= 1'b0;
      done_tgl_ff   <= 1'b0;
      addr_ff       <= ADDR_RESET;
      off_ff        <= OFF_RESET;
      write_ff      <= 1'b0;
      burst_mode_ff <= 1'b0;
      mc_ff         <= 1'b0;
      first_ff      <= 1'b0;
      own_ff        <= 1'b0;
      usize_ff      <= TSIZ_WORD;
      psz_ff        <= PORT_32;
      beats_left_ff <= BEATS_SINGLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (req_s2_ff != req_seen_ff) begin
            req_seen_ff   <= req_s2_ff;
            write_ff      <= u_write_ff;
            burst_mode_ff <= u_burst_ff;
            mc_ff         <= u_mc_ff;
            usize_ff      <= u_size_ff;
            addr_ff       <= u_addr_ff;
            first_ff      <= 1'b1;
            psz_ff        <= PORT_32;
            beats_left_ff <= u_burst_ff ? BEATS_BURST : BEATS_SINGLE;
            // Natural alignment is forced on the start offset.
            if (u_burst_ff || u_size_ff == TSIZ_WORD) begin
              off_ff <= {u_addr_ff[3:2], 2'b00};
            end else if (u_size_ff == TSIZ_HALF) begin
              off_ff <= {u_addr_ff[3:1], 1'b0};
            end else begin
              off_ff <= u_addr_ff[3:0];
            end
            state_ff <= ST_ARB;
          end
        end
        ST_ARB: begin
          if (!bus_grant_n_in && bus_busy_n_in) begin
            own_ff   <= 1'b1;
            state_ff <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          state_ff <= ST_DATA;
        end
        ST_DATA: begin
          if (ack) begin
            first_ff <= 1'b0;
            psz_ff   <= eff_psz;
            off_ff   <= off_ff + step;
            if (first_ff && burst_mode_ff) begin
              beats_left_ff <= blk_beats - 5'h01;
              if (!no_burst_flag_n_in) begin
                burst_mode_ff <= 1'b0;
                state_ff      <= ST_TURN;
              end
            end else begin
              beats_left_ff <= beats_left_ff - 5'h01;
              if (!burst_mode_ff || beats_left_ff == BEATS_SINGLE) begin
                state_ff <= ST_TURN;
              end
            end
          end
        end
        ST_TURN: begin
          // Bus stays owned across fallback singles and narrow beats.
          state_ff <= (beats_left_ff == 5'h00) ? ST_REL : ST_ADDR;
        end
        ST_REL: begin
          own_ff      <= 1'b0;
          done_tgl_ff <= ~done_tgl_ff;
          state_ff    <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Read beats land in the block buffer at the current byte offset.
  always_comb begin
    nxt_buf = buf_ff;
    if (ack && !write_ff) begin
      case (eff_psz)
        PORT_16: nxt_buf[BUF_W-1-16*off_ff[3:1] -: 16] = data_in[31:16];
        PORT_8:  nxt_buf[BUF_W-1-8*off_ff -: 8]        = data_in[31:24];
        default: nxt_buf[BUF_W-1-32*off_ff[3:2] -: 32] = data_in;
      endcase
    end
  end

  always_ff @(posedge bus_clock_output_in or negedge brst_n) begin
    if (!brst_n) begin
      buf_ff <= BUF_RESET;
    end else if (state_ff == ST_IDLE && req_s2_ff != req_seen_ff) begin
      buf_ff <= u_wdata_ff;
    end else begin
      buf_ff <= nxt_buf;
    end
  end

  // Bus outputs.
  assign bus_req_n_out    = ~(state_ff == ST_ARB);
  assign bus_busy_oe_out  = own_ff;
  assign bus_busy_n_out   = ~(own_ff && state_ff != ST_REL);
  assign xfer_start_n_out = ~(state_ff == ST_ADDR);
  assign write_out        = write_ff;
  assign burst_out        = burst_mode_ff;
  // The burst address stays put; the slave walks the words itself.
  assign addr_out = burst_mode_ff ? {addr_ff[ADDR_W-1:2], 2'b00}
                                  : {addr_ff[ADDR_W-1:4], off_ff};

  always_comb begin
    if (burst_mode_ff || first_ff) begin
      tsiz_out = burst_mode_ff ? TSIZ_WORD : usize_ff;
    end else begin
      case (psz_ff)
        PORT_16: tsiz_out = TSIZ_HALF;
        PORT_8:  tsiz_out = TSIZ_BYTE;
        default: tsiz_out = TSIZ_WORD;
      endcase
    end
  end

  // Write data only in the data state, never with the address.
  assign data_oe_out = (state_ff == ST_DATA) && write_ff;
  always_comb begin
    case (eff_psz)
      PORT_16: data_out = {2{buf_ff[BUF_W-1-16*off_ff[3:1] -: 16]}};
      PORT_8:  data_out = {4{buf_ff[BUF_W-1-8*off_ff -: 8]}};
      default: data_out = buf_ff[BUF_W-1-32*off_ff[3:2] -: 32];
    endcase
  end

  assign burst_continues_n_out = ~(state_ff == ST_DATA && burst_mode_ff
                                   && beats_left_ff > BEATS_SINGLE);

  sequence s_addr_phase;
    !xfer_start_n_out;
  endsequence

  sequence s_write_last_ack;
    data_oe_out && !beat_ack_n_in && !burst_mode_ff;
  endsequence

  a_start_one_cycle: assert property (@(posedge bus_clock_output_in) disable iff (!brst_n)
    s_addr_phase |=> xfer_start_n_out && state_ff == ST_DATA)
    else $error("start strobe not a single cycle before data");
  a_wdata_after_addr: assert property (@(posedge bus_clock_output_in) disable iff (!brst_n)
    s_addr_phase and write_out |-> !data_oe_out ##1 data_oe_out)
    else $error("write data not driven right after address phase");
  a_wdata_release: assert property (@(posedge bus_clock_output_in) disable iff (!brst_n)
    s_write_last_ack |=> !data_oe_out)
    else $error("write data held after final acknowledge");
  a_dead_cycle_gap: assert property (@(posedge bus_clock_output_in) disable iff (!brst_n)
    $fell(data_oe_out) |-> !data_oe_out ##1 !data_oe_out)
    else $error("no dead cycle after write drive");
  a_read_capture: assert property (@(posedge bus_clock_output_in) disable iff (!brst_n)
    ack && !write_ff && eff_psz == PORT_32
    |=> buf_ff[BUF_W-1-32*$past(off_ff[3:2]) -: 32] == $past(data_in))
    else $error("read word not captured on acknowledge");
  a_burst_addr_stable: assert property (@(posedge bus_clock_output_in) disable iff (!brst_n)
    burst_mode_ff && state_ff == ST_DATA && $past(state_ff) == ST_DATA |-> $stable(addr_out))
    else $error("burst address moved during burst");
  a_fallback_count: assert property (@(posedge bus_clock_output_in) disable iff (!brst_n)
    ack && first_ff && burst_mode_ff && !no_burst_flag_n_in
    |=> !burst_mode_ff && beats_left_ff == $past(blk_beats) - 5'h01 ##1 state_ff == ST_ADDR)
    else $error("inhibited burst not turned into singles");
  a_continue_last: assert property (@(posedge bus_clock_output_in) disable iff (!brst_n)
    ack && burst_mode_ff && burst_continues_n_out
    |=> state_ff == ST_TURN)
    else $error("burst went on after continue flag negated");
  a_continue_more: assert property (@(posedge bus_clock_output_in) disable iff (!brst_n)
    ack && burst_mode_ff && no_burst_flag_n_in && !burst_continues_n_out
    |=> state_ff == ST_DATA)
    else $error("burst ended while continue flag asserted");
  a_bus_held_atomic: assert property (@(posedge bus_clock_output_in) disable iff (!brst_n)
    state_ff == ST_TURN && beats_left_ff != 5'h00 |-> !bus_busy_n_out ##1 s_addr_phase)
    else $error("bus released inside an atomic sequence");
  a_burst_attrs: assert property (@(posedge bus_clock_output_in) disable iff (!brst_n)
    s_addr_phase and burst_out |-> tsiz_out == TSIZ_WORD && addr_out[1:0] == 2'b00)
    else $error("burst start attributes wrong");
  a_half_align: assert property (@(posedge bus_clock_output_in) disable iff (!brst_n)
    s_addr_phase and tsiz_out == TSIZ_HALF |-> addr_out[0] == 1'b0)
    else $error("half-word access misaligned");

endmodule // sysbus_master

//--- dv/sysbus_slave_model.sv
/*
  Behavioural slave for the system bus master: grant, one wait cycle per beat,
  optional burst inhibit and narrow ports, 16-byte block memory.
  Assumes the bench sets port and inhibit only while the bus is idle.
*/
`timescale 1ns/100ps
module sysbus_slave_model
  import sysbus_pkg::*;
(
  // Bus clock and reset
  input  wire logic        bus_clk_in,
  input  wire logic        resetn_in,
  // Scenario settings
  input  wire logic [1:0]  port_in,
  input  wire logic        inhibit_in,
  // Master outputs
  input  wire logic        bus_req_n_in,
  input  wire logic        xfer_start_n_in,
  input  wire logic        write_in,
  input  wire logic        burst_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [1:0]  tsiz_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        cont_n_in,
  // Slave answers
  output logic             grant_n_out,
  output logic             ack_n_out,
  output logic             no_burst_n_out,
  output logic [31:0]      rdata_out
);
  logic [7:0] mem [16];
  logic [3:0] off_ff;
  logic [3:0] step;
  logic       active_ff;
  logic       wr_ff;
  logic       first_ff;
  logic [1:0] sz_ff;
  logic [3:0] base;
  logic [3:0] lo;
  logic [3:0] nb;
  int         naddr_ff;
  int         nbeat_ff;

  assign step = (port_in == PORT_16) ? 4'h2 : (port_in == PORT_8) ? 4'h1 : 4'h4;
  // A 32-bit port sees laned single transfers; a narrow port starts at lane 0.
  assign base = (port_in == PORT_32) ? {off_ff[3:2], 2'b00} : off_ff;
  assign lo   = (port_in == PORT_32) ? {2'b00, off_ff[1:0]} : 4'h0;
  assign nb   = (port_in != PORT_32) ? step
              : (sz_ff == TSIZ_HALF) ? 4'h2 : (sz_ff == TSIZ_BYTE) ? 4'h1 : 4'h4;

  always_ff @(posedge bus_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      grant_n_out    <= 1'b1;
      ack_n_out      <= 1'b1;
      no_burst_n_out <= 1'b1;
      rdata_out      <= 32'h0;
      off_ff         <= 4'h0;
      active_ff      <= 1'b0;
      wr_ff          <= 1'b0;
      first_ff       <= 1'b0;
      sz_ff          <= TSIZ_WORD;
      naddr_ff       <= 0;
      nbeat_ff       <= 0;
      for (int i = 0; i < 16; i++) begin
        mem[i] <= 8'hA0 + 8'(i);
      end
    end else begin
      grant_n_out    <= bus_req_n_in;
      ack_n_out      <= 1'b1;
      no_burst_n_out <= 1'b1;
      rdata_out      <= ~rdata_out;
      if (!xfer_start_n_in) begin
        naddr_ff  <= naddr_ff + 1;
        active_ff <= 1'b1;
        off_ff    <= addr_in[3:0];
        wr_ff     <= write_in;
        first_ff  <= burst_in;
        sz_ff     <= tsiz_in;
      end else if (active_ff && !ack_n_out) begin
        nbeat_ff <= nbeat_ff + 1;
        off_ff   <= off_ff + step;
        if (wr_ff) begin
          for (int k = 0; k < 4; k++) begin
            if (4'(k) >= lo && 4'(k) < lo + nb) begin
              mem[base + 4'(k)] <= wdata_in[31-8*k -: 8];
            end
          end
        end
        if (cont_n_in || !no_burst_n_out) begin
          active_ff <= 1'b0;
        end
      end else if (active_ff) begin
        ack_n_out <= 1'b0;
        first_ff  <= 1'b0;
        if (first_ff && inhibit_in) begin
          no_burst_n_out <= 1'b0;
        end
        if (!wr_ff) begin
          rdata_out <= {mem[base], mem[base+4'h1], mem[base+4'h2], mem[base+4'h3]};
        end
      end
    end
  end
endmodule // sysbus_slave_model

//--- dv/system_bus_transfer_burst_tb.sv
/*
  Self-checking bench for the system bus master with a slave model.
  Assumes a 100 MHz user clock and an unrelated 32 ns bus clock.
*/
`timescale 1ns/100ps
module system_bus_transfer_burst_tb;
  import sysbus_pkg::*;
  logic         clk_in    = 1'b0;
  logic         bus_clk   = 1'b0;
  logic         resetn_in = 1'b0;
  logic         req_valid = 1'b0;
  logic         req_write = 1'b0;
  logic         req_burst = 1'b0;
  logic         req_mc    = 1'b0;
  logic [1:0]   port_cfg  = PORT_32;
  logic         inhibit   = 1'b0;
  logic [31:0]  req_addr  = 32'h0;
  logic [127:0] req_wdata = 128'h0;
  logic [1:0]   req_size  = TSIZ_WORD;
  logic [1:0]   last_tsiz = TSIZ_WORD;
  logic [31:0]  last_addr = 32'h0;
  logic         req_ready_out, done_out, bus_req_n, busy_n_o, busy_oe, busy_n;
  logic         wr, burst, xs_n, doe, cont_n, grant_n, ack_n, nb_n;
  logic [1:0]   tsiz;
  logic [31:0]  addr, dout, din;
  logic [127:0] rdata_out;
  logic [7:0]   exp_mem [16];
  int           num_errors = 0;
  int           n_tests    = 0;
  int           cyc        = 0;

  always #5 clk_in = ~clk_in;
  always #16 bus_clk = ~bus_clk;
  // Busy line has a pull-up once the master releases it.
  assign busy_n = busy_oe ? busy_n_o : 1'b1;

  // Attributes of the latest address phase, for size and alignment checks.
  always @(posedge bus_clk) begin
    if (!xs_n) begin
      last_tsiz <= tsiz;
      last_addr <= addr;
    end
  end

  sysbus_master DUT (
    .clk_in(clk_in), .resetn_in(resetn_in), .req_valid_in(req_valid),
    .req_ready_out(req_ready_out), .req_write_in(req_write), .req_burst_in(req_burst),
    .req_mc_in(req_mc), .req_size_in(req_size), .req_addr_in(req_addr),
    .req_wdata_in(req_wdata), .done_out(done_out), .rdata_out(rdata_out),
    .bus_clock_output_in(bus_clk), .bus_req_n_out(bus_req_n), .bus_grant_n_in(grant_n),
    .bus_busy_n_in(busy_n), .bus_busy_n_out(busy_n_o), .bus_busy_oe_out(busy_oe),
    .addr_out(addr), .tsiz_out(tsiz), .write_out(wr), .burst_out(burst),
    .xfer_start_n_out(xs_n), .data_in(din), .data_out(dout), .data_oe_out(doe),
    .beat_ack_n_in(ack_n), .no_burst_flag_n_in(nb_n), .burst_continues_n_out(cont_n),
    .port_size_in(port_cfg));

  sysbus_slave_model slave (
    .bus_clk_in(bus_clk), .resetn_in(resetn_in), .port_in(port_cfg), .inhibit_in(inhibit),
    .bus_req_n_in(bus_req_n), .xfer_start_n_in(xs_n), .write_in(wr), .burst_in(burst),
    .addr_in(addr), .tsiz_in(tsiz), .wdata_in(dout), .cont_n_in(cont_n), .grant_n_out(grant_n),
    .ack_n_out(ack_n), .no_burst_n_out(nb_n), .rdata_out(din));

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [127:0] blk();
    logic [127:0] v;
    for (int i = 0; i < 16; i++) begin
      v[127-8*i -: 8] = exp_mem[i];
    end
    return v;
  endfunction

  task automatic run(input logic w, input logic b, input logic mc, input logic [31:0] a,
                     input logic [127:0] wd, input logic [1:0] sz);
    int k;
    @(posedge clk_in);
    req_valid <= 1'b1;
    req_size  <= sz;
    req_write <= w;
    req_burst <= b;
    req_mc    <= mc;
    req_addr  <= a;
    req_wdata <= wd;
    @(posedge clk_in);
    req_valid <= 1'b0;
    @(negedge clk_in);
    check("req_ready_out busy", req_ready_out, 1'b0);
    k = 0;
    do begin
      @(negedge clk_in);
      k++;
    end while (done_out !== 1'b1 && k < 5000);
    check("done_out", done_out, 1'b1);
    check("req_ready_out idle", req_ready_out, 1'b1);
    check("bus_busy_oe_out", busy_oe, 1'b0);
  endtask

  task automatic t_single(input logic [3:0] off, input logic [31:0] w);
    int a0;
    a0 = slave.naddr_ff;
    run(1'b1, 1'b0, 1'b0, 32'h0000_1000 | off, {4{w}}, TSIZ_WORD);
    for (int k = 0; k < 4; k++) begin
      exp_mem[off+4'(k)] = w[31-8*k -: 8];
    end
    run(1'b0, 1'b0, 1'b0, 32'h0000_1000 | off, 128'h0, TSIZ_WORD);
    check("single word", rdata_out[127-32*off[3:2] -: 32], w);
    check("single phases", slave.naddr_ff - a0, 2);
    check("single tsiz", last_tsiz, TSIZ_WORD);
    $display("test single done");
  endtask

  task automatic t_half(input logic [31:0] w);
    run(1'b1, 1'b0, 1'b0, 32'h0000_1007, {4{w}}, TSIZ_HALF);
    exp_mem[6] = w[15:8];
    exp_mem[7] = w[7:0];
    run(1'b0, 1'b0, 1'b0, 32'h0000_1007, 128'h0, TSIZ_HALF);
    check("half word", rdata_out[95:64], {exp_mem[4], exp_mem[5], exp_mem[6], exp_mem[7]});
    check("half tsiz", last_tsiz, TSIZ_HALF);
    check("half addr", last_addr[3:0], 4'h6);
    $display("test half done");
  endtask

  task automatic t_burst(input logic [3:0] off, input logic [1:0] port, input logic inh,
                         input int phases, input int beats);
    int a0;
    int b0;
    a0 = slave.naddr_ff;
    b0 = slave.nbeat_ff;
    @(posedge clk_in);
    port_cfg <= port;
    inhibit  <= inh;
    run(1'b0, 1'b1, port != PORT_32, 32'h0000_2000 | off, 128'h0, TSIZ_WORD);
    check("last tsiz", last_tsiz, !inh ? TSIZ_WORD : (port == PORT_16) ? TSIZ_HALF
          : (port == PORT_8) ? TSIZ_BYTE : TSIZ_WORD);
    check("burst block", rdata_out, blk());
    check("burst phases", slave.naddr_ff - a0, phases);
    check("burst beats", slave.nbeat_ff - b0, beats);
    $display("test burst done");
  endtask

  task automatic t_burst_write(input logic [3:0] off, input logic [127:0] wd);
    int b0;
    @(posedge clk_in);
    port_cfg <= PORT_32;
    inhibit  <= 1'b0;
    b0 = slave.nbeat_ff;
    run(1'b1, 1'b1, 1'b0, 32'h0000_3000 | off, wd, TSIZ_WORD);
    for (int i = 0; i < 16; i++) begin
      exp_mem[i] = wd[127-8*i -: 8];
    end
    check("write beats", slave.nbeat_ff - b0, 4);
    t_burst(off, PORT_32, 1'b0, 1, 4);
    $display("test burst write done");
  endtask

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    for (int i = 0; i < 16; i++) begin
      exp_mem[i] = 8'hA0 + 8'(i);
    end
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_single(4'h4, 32'h1234_5678);
    t_half(32'h0000_BEEF);
    t_burst(4'h8, PORT_32, 1'b0, 1, 4);
    t_burst(4'h4, PORT_32, 1'b1, 4, 4);
    t_burst(4'h0, PORT_16, 1'b0, 1, 8);
    t_burst(4'h0, PORT_16, 1'b1, 8, 8);
    t_burst(4'h0, PORT_8, 1'b0, 1, 16);
    t_burst_write(4'hC, 128'hC0C1C2C3_C4C5C6C7_C8C9CACB_CCCDCECF);
    final_report();
  end
endmodule // system_bus_transfer_burst_tb
